// [rtl/sbit_defines.svh]
// Register offsets, field positions, reset values and timing counts of the interval timer
`ifndef SBIT_DEFINES_SVH
`define SBIT_DEFINES_SVH
`define SBIT_OFF_CTRL   4'h0
`define SBIT_OFF_COUNT  4'h4
`define SBIT_OFF_PERIOD 4'h8
`define SBIT_B_RUN      15
`define SBIT_B_IDLE     13
`define SBIT_B_WBLK     12
`define SBIT_B_CWIP     11
`define SBIT_B_PWIP     10
`define SBIT_B_ECS_HI   9
`define SBIT_B_ECS_LO   8
`define SBIT_B_GATE     7
`define SBIT_B_PS_HI    5
`define SBIT_B_PS_LO    4
`define SBIT_B_SYNC     2
`define SBIT_B_TCS      1
`define SBIT_CTRL_RST   16'h0000
`define SBIT_COUNT_RST  16'h0000
`define SBIT_PERIOD_RST 16'hFFFF
`define SBIT_WIP_EDGES  2'h2
`define SBIT_RESP_OKAY  2'h0
`define SBIT_RESP_SLV   2'h2
`endif

// [rtl/sbit_pkg.sv]
// Types shared by the interval timer
package sbit_pkg;
  typedef enum logic [1:0] {
    SBIT_IDLE = 2'b01,
    SBIT_RESP = 2'b10
  } sbit_chan_e;
endpackage

// [rtl/sbit_timer.sv]
// Sixteen-bit interval timer with AXI4-Lite control and count/period registers
`include "sbit_defines.svh"

// Summary of operation
// R1: One 16-bit counter, timer or event counter
// R2: Four modes from source, sync, gate bits
// R3: Prescaler 1, 8, 64, 256 by select
// R4: Resync stage placed after the prescaler
// R5: run_enable starts and stops counting
// R6: idle_stop halts counting during Idle
// R7: async_write_block drops writes while pending
// R8: count_write_pending shows async count write
// R9: period_write_pending shows async period write
// R10: ext_clock_select picks the external source
// R11: Gate bit ignored with external source
// R12: ext_clock_sync ignored with internal clock
// R13: clock_source_select picks external or internal
// R14: Count writes ignored in running sync mode
// R15: Unused control bits read zero
// R16: Async counter keeps counting in Sleep
// R17: Software uses sync mode for capture base
// R18: Match period, wrap to zero, flag event
// R19: Gated mode counts while gate high
module sbit_timer
  import sbit_pkg::*;
#(
  parameter int AW = 4
) (
  input  wire logic          mclk,
  input  wire logic          srst,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic [2:0]    s_axi_awprot,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  output logic [1:0]         s_axi_bresp,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic [2:0]    s_axi_arprot,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  input  wire logic          extClkPin,
  input  wire logic          fastRcClk,
  input  wire logic          oscClk,
  input  wire logic          cycleClk,
  input  wire logic          idleMode,
  input  wire logic          sleepMode,
  output logic               periodEvent
);
  // The register decode looks at four address bits
  if (AW < 4) begin : g_aw_check
    $error("AW must be at least 4");
  end

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  sbit_chan_e   wSt_r, wSt_nxt, rSt_r, rSt_nxt;
  logic         awHave_r, awHave_nxt, wHave_r, wHave_nxt;
  logic [AW-1:0] awA_r, awA_nxt;
  logic [31:0]  wD_r, wD_nxt, rD_r, rD_nxt;
  logic [3:0]   wS_r, wS_nxt;
  logic [1:0]   bResp_r, bResp_nxt, rResp_r, rResp_nxt;
  logic         wrGo, ctrlWr, cntWr, perWr;
  logic [15:0]  ctrl_r, ctrl_nxt, wrVal, ctrlRd;

  assign s_axi_awready = (wSt_r == SBIT_IDLE) && !awHave_r;
  assign s_axi_wready  = (wSt_r == SBIT_IDLE) && !wHave_r;
  assign s_axi_bvalid  = (wSt_r == SBIT_RESP);
  assign s_axi_bresp   = bResp_r;
  assign s_axi_arready = (rSt_r == SBIT_IDLE);
  assign s_axi_rvalid  = (rSt_r == SBIT_RESP);
  assign s_axi_rdata   = rD_r;
  assign s_axi_rresp   = rResp_r;

  // Both halves of a write are held until the pair is complete
  assign wrGo   = (wSt_r == SBIT_IDLE) && awHave_r && wHave_r;
  // Lanes follow the strobe captured with the data, not the live bus
  assign wrVal  = {wS_r[1] ? wD_r[15:8] : 8'h00, wS_r[0] ? wD_r[7:0] : 8'h00};
  assign ctrlWr = wrGo && (awA_r[3:0] == `SBIT_OFF_CTRL);
  assign cntWr  = wrGo && (awA_r[3:0] == `SBIT_OFF_COUNT);
  assign perWr  = wrGo && (awA_r[3:0] == `SBIT_OFF_PERIOD);

  always_comb begin
    awHave_nxt = awHave_r;
    wHave_nxt  = wHave_r;
    awA_nxt    = awA_r;
    wD_nxt     = wD_r;
    wS_nxt     = wS_r;
    wSt_nxt    = wSt_r;
    bResp_nxt  = bResp_r;
    if (s_axi_awvalid && s_axi_awready) begin
      awHave_nxt = 1'b1;
      awA_nxt    = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wHave_nxt = 1'b1;
      wD_nxt    = s_axi_wdata;
      wS_nxt    = s_axi_wstrb;
    end
    case (wSt_r)
      SBIT_IDLE: begin
        if (wrGo) begin
          wSt_nxt    = SBIT_RESP;
          awHave_nxt = 1'b0;
          wHave_nxt  = 1'b0;
          bResp_nxt  = (ctrlWr || cntWr || perWr) ? `SBIT_RESP_OKAY : `SBIT_RESP_SLV;
        end
      end
      SBIT_RESP: begin
        if (s_axi_bready) wSt_nxt = SBIT_IDLE;
      end
      default: wSt_nxt = SBIT_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  logic run, idleStop, wrBlock, gateEn, syncEn, extSel;
  logic [1:0] ecs, psSel;
  assign run      = ctrl_r[`SBIT_B_RUN];
  assign idleStop = ctrl_r[`SBIT_B_IDLE];
  assign wrBlock  = ctrl_r[`SBIT_B_WBLK];
  assign ecs      = ctrl_r[`SBIT_B_ECS_HI:`SBIT_B_ECS_LO];
  assign gateEn   = ctrl_r[`SBIT_B_GATE];
  assign psSel    = ctrl_r[`SBIT_B_PS_HI:`SBIT_B_PS_LO];
  assign syncEn   = ctrl_r[`SBIT_B_SYNC];
  assign extSel   = ctrl_r[`SBIT_B_TCS];

  always_comb begin
    ctrl_nxt = ctrl_r;
    if (ctrlWr) begin
      // Only implemented, writable bits are kept; pending flags live elsewhere
      ctrl_nxt = wrVal & 16'hB3B6; // [R15]
    end
  end

  // ----------------------------------------------------------------
  // Clock path: source, gate, prescaler, resync
  // ----------------------------------------------------------------
  logic       srcLvl, srcPrev_r, srcEdge, tickRaw, halt, preTick, syncMode, asyncMode;
  logic       syncTick_r, syncTick_nxt, countTick;
  logic [7:0] preCnt_r, preCnt_nxt, preLim;

  always_comb begin
    case (ecs) // [R10]
      2'h3:    srcLvl = fastRcClk;
      2'h2:    srcLvl = oscClk;
      2'h1:    srcLvl = cycleClk;
      default: srcLvl = extClkPin;
    endcase
  end
  assign srcEdge   = srcLvl && !srcPrev_r;
  assign syncMode  = extSel && syncEn; // [R12]
  assign asyncMode = extSel && !syncEn; // [R2]
  // The internal clock and the resync stage both stop in Sleep; async counting does not
  assign halt = !run || (idleMode && idleStop) || (sleepMode && !asyncMode); // [R5] [R6] [R16]
  // Gate bit only matters on the internal clock
  assign tickRaw = !halt && (extSel ? srcEdge : (!gateEn || extClkPin)); // [R13] [R11] [R19]

  always_comb begin
    case (psSel) // [R3]
      2'h3:    preLim = 8'hFF;
      2'h2:    preLim = 8'h3F;
      2'h1:    preLim = 8'h07;
      default: preLim = 8'h00;
    endcase
  end
  assign preTick = tickRaw && (preCnt_r >= preLim);

  always_comb begin
    preCnt_nxt = preCnt_r;
    if (!run) preCnt_nxt = 8'h00;
    else if (preTick) preCnt_nxt = 8'h00;
    else if (tickRaw) preCnt_nxt = preCnt_r + 8'h01;
    syncTick_nxt = preTick && syncMode; // [R4]
  end
  assign countTick = syncMode ? (syncTick_r && !halt) : (preTick && !syncMode);

  // ----------------------------------------------------------------
  // Count, period and posted async writes
  // ----------------------------------------------------------------
  logic [15:0] count_r, count_nxt, period_r, period_nxt, cStage_r, cStage_nxt;
  logic [15:0] pStage_r, pStage_nxt;
  logic        cPend_r, cPend_nxt, pPend_r, pPend_nxt, cAcc, pAcc, cDone, pDone;
  logic [1:0]  cEdg_r, cEdg_nxt, pEdg_r, pEdg_nxt;
  logic        evt_nxt, blocked;

  // A posted write is done after enough edges of the asynchronous source
  assign blocked = wrBlock && (cPend_r || pPend_r); // [R7]
  assign cAcc  = cntWr && !blocked && !(run && syncMode); // [R14]
  assign pAcc  = perWr && !blocked;
  assign cDone = cPend_r && srcEdge && (cEdg_r == `SBIT_WIP_EDGES - 2'h1);
  assign pDone = pPend_r && srcEdge && (pEdg_r == `SBIT_WIP_EDGES - 2'h1);

  always_comb begin
    cPend_nxt  = cPend_r;
    pPend_nxt  = pPend_r;
    cEdg_nxt   = cEdg_r;
    pEdg_nxt   = pEdg_r;
    cStage_nxt = cStage_r;
    pStage_nxt = pStage_r;
    period_nxt = period_r;
    count_nxt  = count_r;
    evt_nxt    = 1'b0;
    if (cPend_r && srcEdge) cEdg_nxt = cEdg_r + 2'h1;
    if (pPend_r && srcEdge) pEdg_nxt = pEdg_r + 2'h1;
    if (countTick) begin
      if (count_r == period_r) begin // [R18]
        count_nxt = 16'h0000;
        evt_nxt   = 1'b1;
      end else begin
        count_nxt = count_r + 16'h0001; // [R1]
      end
    end
    if (cDone) begin
      count_nxt = cStage_r;
      cPend_nxt = 1'b0;
    end
    if (pDone) begin
      period_nxt = pStage_r;
      pPend_nxt  = 1'b0;
    end
    // A new write in the completing cycle restarts the pending flag unless async_write_block drops it
    if (cAcc && asyncMode) begin
      cPend_nxt  = 1'b1; // [R8]
      cEdg_nxt   = 2'h0;
      cStage_nxt = wrVal;
    end else if (cAcc) begin
      count_nxt = wrVal;
    end
    if (pAcc && asyncMode) begin
      pPend_nxt  = 1'b1; // [R9]
      pEdg_nxt   = 2'h0;
      pStage_nxt = wrVal;
    end else if (pAcc) begin
      period_nxt = wrVal;
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  assign ctrlRd = {ctrl_r[15:12], cPend_r, pPend_r, ctrl_r[9:0]};

  always_comb begin
    rSt_nxt   = rSt_r;
    rD_nxt    = rD_r;
    rResp_nxt = rResp_r;
    case (rSt_r)
      SBIT_IDLE: begin
        if (s_axi_arvalid) begin
          rSt_nxt   = SBIT_RESP;
          rResp_nxt = `SBIT_RESP_OKAY;
          case (s_axi_araddr[3:0])
            `SBIT_OFF_CTRL:   rD_nxt = {16'h0000, ctrlRd};
            `SBIT_OFF_COUNT:  rD_nxt = {16'h0000, count_r};
            `SBIT_OFF_PERIOD: rD_nxt = {16'h0000, period_r};
            default: begin
              rD_nxt    = 32'h0000_0000;
              rResp_nxt = `SBIT_RESP_SLV;
            end
          endcase
        end
      end
      SBIT_RESP: begin
        if (s_axi_rready) rSt_nxt = SBIT_IDLE;
      end
      default: rSt_nxt = SBIT_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      wSt_r <= SBIT_IDLE;
      rSt_r <= SBIT_IDLE;
      awHave_r <= 1'b0;
      wHave_r <= 1'b0;
      awA_r <= '0;
      wD_r <= 32'h0000_0000;
      wS_r <= 4'h0;
      rD_r <= 32'h0000_0000;
      bResp_r <= `SBIT_RESP_OKAY;
      rResp_r <= `SBIT_RESP_OKAY;
      ctrl_r <= `SBIT_CTRL_RST;
      srcPrev_r <= 1'b0;
      preCnt_r <= 8'h00;
      syncTick_r <= 1'b0;
      count_r <= `SBIT_COUNT_RST;
      period_r <= `SBIT_PERIOD_RST;
      cStage_r <= 16'h0000;
      pStage_r <= 16'h0000;
      cPend_r <= 1'b0;
      pPend_r <= 1'b0;
      cEdg_r <= 2'h0;
      pEdg_r <= 2'h0;
      periodEvent <= 1'b0;
    end else begin
      wSt_r <= wSt_nxt;
      rSt_r <= rSt_nxt;
      awHave_r <= awHave_nxt;
      wHave_r <= wHave_nxt;
      awA_r <= awA_nxt;
      wD_r <= wD_nxt;
      wS_r <= wS_nxt;
      rD_r <= rD_nxt;
      bResp_r <= bResp_nxt;
      rResp_r <= rResp_nxt;
      ctrl_r <= ctrl_nxt;
      srcPrev_r <= srcLvl;
      preCnt_r <= preCnt_nxt;
      syncTick_r <= syncTick_nxt;
      count_r <= count_nxt;
      period_r <= period_nxt;
      cStage_r <= cStage_nxt;
      pStage_r <= pStage_nxt;
      cPend_r <= cPend_nxt;
      pPend_r <= pPend_nxt;
      cEdg_r <= cEdg_nxt;
      pEdg_r <= pEdg_nxt;
      periodEvent <= evt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  reserved_zero_a: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr[3:0] == `SBIT_OFF_CTRL |=> s_axi_rdata[14] == 1'b0 &&
    s_axi_rdata[6] == 1'b0 && s_axi_rdata[3] == 1'b0 && s_axi_rdata[0] == 1'b0 &&
    s_axi_rdata[31:16] == 16'h0000) // [R15]
    else $error("reserved control bit read as one");
  ctrl_unused_a: assert property (ctrl_r[14] == 1'b0 && ctrl_r[6] == 1'b0 &&
    ctrl_r[3] == 1'b0 && ctrl_r[0] == 1'b0) // [R15]
    else $error("unimplemented control bit stored");
  period_wrap_a: assert property (countTick && count_r == period_r && !cDone && !cAcc
    |=> count_r == 16'h0000 && periodEvent) // [R18]
    else $error("count did not wrap on period match");
  stop_hold_a: assert property (!run && !cDone && !cAcc |=> $stable(count_r)) // [R5]
    else $error("count moved while stopped");
  idle_halt_a: assert property (idleMode && idleStop && !cDone && !cAcc
    |=> $stable(count_r)) // [R6]
    else $error("count moved in idle with idle_stop");
  sync_write_a: assert property (cntWr && run && syncMode && !cDone
    |=> $past(countTick) || $stable(count_r)) // [R14]
    else $error("count write taken in running sync mode");
  wip_set_a: assert property (cntWr && asyncMode && !blocked |=> cPend_r && ctrlRd[11]) // [R8]
    else $error("count_write_pending not set");
  pwip_set_a: assert property (perWr && asyncMode && !blocked |=> pPend_r && ctrlRd[10]) // [R9]
    else $error("period_write_pending not set");
  write_block_a: assert property (perWr && wrBlock && pPend_r && !pDone
    |=> $stable(pStage_r) && $stable(period_r)) // [R7]
    else $error("blocked period write was taken");
  gate_low_a: assert property (!extSel && gateEn && !extClkPin |-> !tickRaw) // [R19]
    else $error("gated timer counted with gate low");
  prescale_a: assert property (psSel == 2'h1 && !extSel && !gateEn && !halt &&
    preCnt_r == 8'h00 ##1 (psSel == 2'h1 && !extSel && !gateEn && !halt) [*7]
    |-> preTick && preCnt_r == 8'h07) // [R3]
    else $error("prescaler ratio 1:8 not kept");

  wrap_c: cover property (countTick && count_r == period_r);
  async_c: cover property (cPend_r ##[1:50] !cPend_r);
  gated_c: cover property (!extSel && gateEn && tickRaw);
  sleep_c: cover property (sleepMode && asyncMode && countTick);
endmodule

// [dv/sbit_src_model.sv]
// External clock sources and gate pin driven against the interval timer
module sbit_src_model (
  input  wire logic mclk,
  input  wire logic srcOn,
  input  wire logic gateHi,
  output logic      extClkPin,
  output logic      fastRcClk,
  output logic      oscClk,
  output logic      cycleClk
);
  timeunit 1ns;
  timeprecision 1ps;

  int unsigned phase_r = 0;

  // Free phase counter; each source uses its own half period (2, 3, 4, 5)
  // It never wraps within a run, so no source gets a short period
  always @(posedge mclk) begin
    phase_r <= phase_r + 1;
  end

  // Sources stand still outside a burst, low except extClkPin while gateHi, so no stray edges reach the timer
  always @(posedge mclk) begin
    extClkPin <= gateHi | (srcOn & ((phase_r / 2) % 2 == 1));
    fastRcClk <= srcOn & ((phase_r / 3) % 2 == 1);
    oscClk    <= srcOn & ((phase_r / 4) % 2 == 1);
    cycleClk  <= srcOn & ((phase_r / 5) % 2 == 1);
  end
endmodule

// [dv/testbench.sv]
// Self-checking bench for the interval timer: register bus, modes, prescaler, async writes
`include "sbit_defines.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        mclk, srst, idleMode, sleepMode, srcOn, gateHi;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rd;
  logic [1:0]  rsp;
  logic        awready, wready, bvalid, arready, rvalid, periodEvent;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        extClkPin, fastRcClk, oscClk, cycleClk;
  int          failures, n_tests, wt, k, t;
  int          cyc = 0;
  logic [15:0] v;

  sbit_timer dut_u (.mclk(mclk), .srst(srst), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .extClkPin(extClkPin), .fastRcClk(fastRcClk),
    .oscClk(oscClk), .cycleClk(cycleClk), .idleMode(idleMode), .sleepMode(sleepMode),
    .periodEvent(periodEvent));

  sbit_src_model src_u (.mclk(mclk), .srcOn(srcOn), .gateHi(gateHi), .extClkPin(extClkPin),
    .fastRcClk(fastRcClk), .oscClk(oscClk), .cycleClk(cycleClk));

  // ---------------------------------------------------------------
  // Clock, timeout, reporting
  // ---------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Whole run needs well under 10k cycles; anything past 20000 cycles is a hang
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      report_and_stop();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Counts from free clocks are only known to within one tick of phase
  task automatic near(input string nm, input logic [15:0] s, input int e);
    chk(nm, {31'h0, (s + 17'h1 >= e) && (s <= e + 1)}, 32'h1);
  endtask

  task automatic tick();
    @(posedge mclk);
    wt++;
  endtask

  // ---------------------------------------------------------------
  // AXI4-Lite master
  // ---------------------------------------------------------------
  task automatic axw(input logic [3:0] a, input logic [15:0] d);
    bit ad, wd;
    ad = 0;
    wd = 0;
    wt = 0;
    awaddr  <= a;
    wdata   <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    while (!(ad && wd) && wt < 64) begin
      tick();
      if (!ad && awready === 1'b1) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (!wd && wready === 1'b1) begin
        wd = 1;
        wvalid <= 1'b0;
      end
    end
    do tick(); while (bvalid !== 1'b1 && wt < 64);
    rsp = bresp;
    if (wt >= 64) failures++;
  endtask

  task automatic axr(input logic [3:0] a);
    wt = 0;
    araddr  <= a;
    arvalid <= 1'b1;
    do tick(); while (arready !== 1'b1 && wt < 64);
    arvalid <= 1'b0;
    do tick(); while (rvalid !== 1'b1 && wt < 64);
    rd = rdata;
    rsp = rresp;
    if (wt >= 64) failures++;
  endtask

  task automatic still(input string nm, input logic e);
    logic [31:0] a;
    axr(`SBIT_OFF_COUNT);
    a = rd;
    repeat (12) @(posedge mclk);
    axr(`SBIT_OFF_COUNT);
    chk(nm, {31'h0, rd === a}, {31'h0, e});
  endtask

  function automatic int ps_exp(input int code, input int n);
    int dv;
    dv = (code == 0) ? 1 : (code == 1) ? 8 : (code == 2) ? 64 : 256;
    // The run bit stands for three bus cycles beyond the wait
    return (dv * n + 3) / dv;
  endfunction

  // Half periods of the model: pin 2, cycle 5, osc 4, fast RC 3
  function automatic int src_exp(input int code);
    int h[4] = '{2, 5, 4, 3};
    return 120 / (2 * h[code]);
  endfunction

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {srst, idleMode, sleepMode, srcOn, gateHi} = 5'b10000;
    // Answer readies stay high, so no release clashes with the next request
    {awvalid, wvalid, bready, arvalid, rready} = 5'b00101;
    {awaddr, araddr, wdata} = 40'h0;
    wstrb = 4'h3;
    {failures, n_tests} = 0;
    void'($urandom(8));
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    axr(`SBIT_OFF_CTRL);
    chk("ctrl reset", rd, 32'h0000_0000);
    axr(`SBIT_OFF_PERIOD);
    chk("period reset", rd, 32'h0000_FFFF);
    axr(4'hC);
    chk("unmapped rresp", rsp, 2'h2);
    axw(4'hC, 16'h1234);
    chk("unmapped bresp", rsp, 2'h2);
    for (int i = 0; i < 5; i++) begin
      v = (i == 0) ? 16'hFFFF : 16'($urandom);
      axw(`SBIT_OFF_CTRL, v);
      chk("ctrl bresp", rsp, 2'h0);
      axr(`SBIT_OFF_CTRL);
      chk("ctrl rresp", rsp, 2'h0);
      chk("ctrl readback", rd, {16'h0000, v & 16'hB3B6});
    end
    wstrb <= 4'h2;
    axw(`SBIT_OFF_CTRL, 16'hFFFF);
    axr(`SBIT_OFF_CTRL);
    wstrb <= 4'h3;
    chk("ctrl byte strobe", rd, 32'h0000_B300);
    $display("test registers done");
    for (int c = 0; c < 4; c++) begin
      k = 1 + $urandom % 6;
      axw(`SBIT_OFF_CTRL, 16'h0000);
      axw(`SBIT_OFF_COUNT, 16'h0000);
      axw(`SBIT_OFF_CTRL, 16'h8000 | 16'(c << 4));
      repeat ((c == 0 ? 1 : c == 1 ? 8 : c == 2 ? 64 : 256) * k) @(posedge mclk);
      axw(`SBIT_OFF_CTRL, 16'h0000);
      axr(`SBIT_OFF_COUNT);
      near("prescaled count", rd[15:0], ps_exp(c, k));
    end
    $display("test prescaler done");
    v = 16'(3 + $urandom % 14);
    axw(`SBIT_OFF_PERIOD, v);
    axw(`SBIT_OFF_COUNT, 16'h0000);
    axw(`SBIT_OFF_CTRL, 16'h8000);
    for (int j = 0; j < 2; j++) begin
      t = 0;
      do begin
        @(posedge mclk);
        t++;
      end while (periodEvent !== 1'b1 && t < 64);
    end
    chk("event spacing", t, 32'(v) + 1);
    $display("test period done");
    // A short period could bring the count back to the same value between reads
    axw(`SBIT_OFF_PERIOD, 16'hFFFF);
    axw(`SBIT_OFF_CTRL, 16'hA000);
    idleMode <= 1'b1;
    still("idle stop", 1'b1);
    axw(`SBIT_OFF_CTRL, 16'h8000);
    still("idle run", 1'b0);
    idleMode  <= 1'b0;
    sleepMode <= 1'b1;
    still("sleep sync", 1'b1);
    axw(`SBIT_OFF_CTRL, 16'h8002);
    srcOn <= 1'b1;
    still("sleep async", 1'b0);
    srcOn     <= 1'b0;
    sleepMode <= 1'b0;
    axw(`SBIT_OFF_CTRL, 16'h8080);
    still("gate low", 1'b1);
    gateHi <= 1'b1;
    still("gate high", 1'b0);
    axw(`SBIT_OFF_CTRL, 16'h8086);
    still("gate ignored", 1'b1);
    gateHi <= 1'b0;
    $display("test halt and gate done");
    axw(`SBIT_OFF_CTRL, 16'h0006);
    axw(`SBIT_OFF_COUNT, 16'h0010);
    axw(`SBIT_OFF_CTRL, 16'h8006);
    axw(`SBIT_OFF_COUNT, 16'h0055);
    axr(`SBIT_OFF_COUNT);
    chk("sync count write", rd, 32'h0000_0010);
    for (int c = 0; c < 4; c++) begin
      axw(`SBIT_OFF_CTRL, 16'h0000);
      axw(`SBIT_OFF_COUNT, 16'h0000);
      axw(`SBIT_OFF_CTRL, 16'h8002 | 16'(c << 8));
      srcOn <= 1'b1;
      repeat (120) @(posedge mclk);
      srcOn <= 1'b0;
      axr(`SBIT_OFF_COUNT);
      near("source count", rd[15:0], src_exp(c));
    end
    $display("test sources done");
    for (int b = 0; b < 2; b++) begin
      v = 16'($urandom);
      axw(`SBIT_OFF_CTRL, b ? 16'h1002 : 16'h0002);
      axw(`SBIT_OFF_COUNT, 16'h1111);
      axw(`SBIT_OFF_COUNT, v);
      axw(`SBIT_OFF_PERIOD, v ^ 16'h5A5A);
      axr(`SBIT_OFF_CTRL);
      chk("pending flags", rd[11:10], b ? 2'b10 : 2'b11);
      srcOn <= 1'b1;
      repeat (30) @(posedge mclk);
      srcOn <= 1'b0;
      axr(`SBIT_OFF_CTRL);
      chk("flags clear", rd[11:10], 2'b00);
      axr(`SBIT_OFF_COUNT);
      chk("async count", rd[15:0], b ? 16'h1111 : v);
      axr(`SBIT_OFF_PERIOD);
      chk("async period", rd[15:0], b ? 16'h1111 ^ 16'h1111 ^ k[15:0] : v ^ 16'h5A5A);
      k = {16'h0, v ^ 16'h5A5A};
    end
    $display("test async writes done");
    report_and_stop();
  end
endmodule
